//--- core/sensor_cmd_cfg.svh
// offsets, field positions, codes and reset values of the command and status block
`ifndef SENSOR_CMD_CFG_SVH
`define SENSOR_CMD_CFG_SVH

// ==========================================================
// register offsets
`define OFS_PARAMETER_BOX     8'h17
`define OFS_COMMAND_MAILBOX   8'h18
`define OFS_RESPONSE_CODE     8'h20
`define OFS_INTERRUPT_FLAGS   8'h21
`define OFS_VISIBLE_LOW       8'h22
`define OFS_VISIBLE_HIGH      8'h23
`define OFS_INFRARED_LOW      8'h24
`define OFS_INFRARED_HIGH     8'h25

// ==========================================================
// reset values
`define RST_BYTE              8'h00
`define RST_WORD              16'h0000
`define RST_FLAGS             6'h00

// ==========================================================
// interrupt flag positions
`define BIT_CMD_DONE          5
`define BIT_PROX_BASE         2
`define NUM_PROX              3
`define FLD_AMBIENT_LSB       0
`define FLD_AMBIENT_MSB       1
`define WIDTH_FLAGS           6

// ==========================================================
// response codes
`define BIT_ERROR             7
`define ERR_INVALID_COMMAND   8'h80
`define ERR_PROX_ONE_OVF      8'h88
`define ERR_PROX_TWO_OVF      8'h89
`define ERR_PROX_THREE_OVF    8'h8A
`define ERR_VISIBLE_OVF       8'h8C
`define ERR_INFRARED_OVF      8'h8D
`define ERR_AUXILIARY_OVF     8'h8E
`define COUNTER_HIGH_ZERO     4'h0
`define COUNTER_STEP          4'h1

// ==========================================================
// command codes and modes
`define CMD_NO_OPERATION      8'h00
`define CMD_RESET             8'h01
`define INT_MODE_AUTO         1'b1
`define PROX_MODE_STICKY      2'h3

`endif

//--- core/sensor_cmd_pkg.sv
// types shared by the command and status block
package sensor_cmd_pkg;

  // ==========================================================
  // state of the register front end
  typedef struct packed {
    logic [7:0]  command;
    logic [7:0]  param;
    logic [5:0]  flags;
    logic [15:0] vis;
    logic [15:0] ir;
    logic [7:0]  rdata;
    logic        wake;
    logic        issue;
    logic [7:0]  issue_code;
    logic        int_n;
  } core_state_t;

  // ==========================================================
  // state of the response tracker
  typedef struct packed {
    logic [7:0] code;
  } resp_state_t;

endpackage

//--- core/response_tracker.sv
// response register: rolling execution counter or held error code
`timescale 1ns/1ps
`include "sensor_cmd_cfg.svh"

module response_tracker (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       clear_req,
  input  wire logic       done,
  input  wire logic       err_valid,
  input  wire logic [7:0] err_code,
  input  wire logic       host_wr,
  input  wire logic [7:0] host_wdata,
  output logic      [7:0] resp
);

  // ==========================================================
  // state
  sensor_cmd_pkg::resp_state_t st_r;
  sensor_cmd_pkg::resp_state_t st_nxt;
  logic [7:0]                  base;

  always_comb begin
    base   = st_r.code;
    st_nxt = st_r;
    if (host_wr) begin
      base = host_wdata;
    end
    if (clear_req) begin
      base = `RST_BYTE;
    end
    st_nxt.code = base;
    // an error arriving with the clear wins over it
    if (err_valid && !base[`BIT_ERROR]) begin
      st_nxt.code = err_code;
    end else if (done && !base[`BIT_ERROR]) begin
      st_nxt.code = {`COUNTER_HIGH_ZERO, base[3:0] + `COUNTER_STEP};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r.code <= `RST_BYTE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign resp = st_r.code;

  // ==========================================================
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  a_error_loaded: assert property (
    err_valid && !resp[`BIT_ERROR] && !host_wr
    |=> resp == $past(err_code) && resp[`BIT_ERROR])
    else $error("error code not loaded");

  a_error_held: assert property (
    resp[`BIT_ERROR] && !clear_req && !host_wr |=> resp == $past(resp))
    else $error("error code not held");

  a_counter_step: assert property (
    done && !err_valid && !clear_req && !host_wr && !resp[`BIT_ERROR]
    |=> resp[3:0] == $past(resp[3:0]) + 4'h1 && resp[7:4] == 4'h0)
    else $error("counter did not step");

endmodule

//--- core/sensor_command_core.sv
// command mailbox, response, interrupt flags and light results of the sensor
`timescale 1ns/1ps
`include "sensor_cmd_cfg.svh"

module sensor_command_core #(
  parameter int NUM_PROX = `NUM_PROX
) (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  output logic             WAKE,
  output logic             CMD_ISSUE,
  output logic      [7:0]  CMD_CODE,
  output logic      [7:0]  PARAMETER_VALUE,
  input  wire logic        CMD_DONE,
  input  wire logic        CMD_INVALID,
  input  wire logic [5:0]  OVF_EVENT,
  input  wire logic [2:0]  PROX_EVENT,
  input  wire logic        AMBIENT_EVENT,
  input  wire logic [1:0]  AMBIENT_STATUS,
  input  wire logic        AUTO_CLEAR,
  input  wire logic        INT_MODE,
  input  wire logic [5:0]  IRQ_ENABLE,
  input  wire logic [5:0]  PROX_ALERT_MODE,
  input  wire logic        VIS_LOAD,
  input  wire logic [15:0] VIS_RESULT,
  input  wire logic        IR_LOAD,
  input  wire logic [15:0] IR_RESULT,
  output logic      [7:0]  RESPONSE_CODE,
  output logic             INT_N
);

  // ==========================================================
  // state and decode
  sensor_cmd_pkg::core_state_t st_r;
  sensor_cmd_pkg::core_state_t st_nxt;

  logic [7:0] resp;
  logic       cmd_wr;
  logic       clear_cmd;
  logic       cmd_accept;
  logic       clear_req;
  logic       resp_wr;
  logic       flags_wr;
  logic       err_valid;
  logic [7:0] err_code;
  logic [5:0] flags;

  assign cmd_wr     = REG_WR && (REG_ADDR == `OFS_COMMAND_MAILBOX);
  assign resp_wr    = REG_WR && (REG_ADDR == `OFS_RESPONSE_CODE);
  assign flags_wr   = REG_WR && (REG_ADDR == `OFS_INTERRUPT_FLAGS);
  assign clear_cmd  = (REG_WDATA == `CMD_NO_OPERATION) || (REG_WDATA == `CMD_RESET);
  // a held error lets only the two clearing commands through
  assign cmd_accept = cmd_wr && (!resp[`BIT_ERROR] || clear_cmd);
  assign clear_req  = cmd_wr && clear_cmd && resp[`BIT_ERROR];
  assign err_valid  = CMD_INVALID || (|OVF_EVENT);
  assign flags      = st_r.flags;

  // ==========================================================
  // error code selection
  // invalid command outranks overflows; lowest overflow index wins on a tie
  function automatic logic [7:0] pick_error(input logic invalid, input logic [5:0] ovf);
    logic [7:0] code;
    code = `ERR_INVALID_COMMAND;
    if (!invalid) begin
      if (ovf[0]) begin
        code = `ERR_PROX_ONE_OVF;
      end else if (ovf[1]) begin
        code = `ERR_PROX_TWO_OVF;
      end else if (ovf[2]) begin
        code = `ERR_PROX_THREE_OVF;
      end else if (ovf[3]) begin
        code = `ERR_VISIBLE_OVF;
      end else if (ovf[4]) begin
        code = `ERR_INFRARED_OVF;
      end else begin
        code = `ERR_AUXILIARY_OVF;
      end
    end
    return code;
  endfunction

  assign err_code = pick_error(CMD_INVALID, OVF_EVENT);

  // ==========================================================
  // response register
  // completion comes whenever the sequencer reports it, never on a fixed delay
  response_tracker response_tracker_inst (
    .clk        (CLK),
    .nrst       (NRST),
    .clear_req  (clear_req),
    .done       (CMD_DONE),
    .err_valid  (err_valid),
    .err_code   (err_code),
    .host_wr    (resp_wr),
    .host_wdata (REG_WDATA),
    .resp       (resp)
  );

  // ==========================================================
  // next state
  always_comb begin
    logic [5:0] f;
    f          = st_r.flags;
    st_nxt     = st_r;
    st_nxt.wake  = 1'b0;
    st_nxt.issue = 1'b0;
    // register writes
    if (cmd_wr) begin
      st_nxt.command = REG_WDATA;
      st_nxt.wake    = 1'b1;
    end
    if (cmd_accept) begin
      st_nxt.issue      = 1'b1;
      st_nxt.issue_code = REG_WDATA;
    end
    if (REG_WR && (REG_ADDR == `OFS_PARAMETER_BOX)) begin
      st_nxt.param = REG_WDATA;
    end
    if (REG_WR && (REG_ADDR == `OFS_VISIBLE_LOW)) begin
      st_nxt.vis[7:0] = REG_WDATA;
    end
    if (REG_WR && (REG_ADDR == `OFS_VISIBLE_HIGH)) begin
      st_nxt.vis[15:8] = REG_WDATA;
    end
    if (REG_WR && (REG_ADDR == `OFS_INFRARED_LOW)) begin
      st_nxt.ir[7:0] = REG_WDATA;
    end
    if (REG_WR && (REG_ADDR == `OFS_INFRARED_HIGH)) begin
      st_nxt.ir[15:8] = REG_WDATA;
    end
    // measurement loads win over host writes; a held error does not gate them
    if (VIS_LOAD) begin
      st_nxt.vis = VIS_RESULT;
    end
    if (IR_LOAD) begin
      st_nxt.ir = IR_RESULT;
    end
    // flag clears first, sets after, so a set in the clearing cycle survives
    if (flags_wr) begin
      f = f & ~REG_WDATA[`WIDTH_FLAGS-1:0];
    end
    if ((INT_MODE == `INT_MODE_AUTO) && AUTO_CLEAR) begin
      f[`BIT_CMD_DONE] = 1'b0;
      f[`FLD_AMBIENT_MSB:`FLD_AMBIENT_LSB] = 2'h0;
      for (int i = 0; i < NUM_PROX; i++) begin
        if (PROX_ALERT_MODE[2*i +: 2] != `PROX_MODE_STICKY) begin
          f[`BIT_PROX_BASE + i] = 1'b0;
        end
      end
    end
    if (CMD_DONE) begin
      f[`BIT_CMD_DONE] = 1'b1;
    end
    for (int i = 0; i < NUM_PROX; i++) begin
      if (PROX_EVENT[i]) begin
        f[`BIT_PROX_BASE + i] = 1'b1;
      end
    end
    if (AMBIENT_EVENT) begin
      f[`FLD_AMBIENT_MSB:`FLD_AMBIENT_LSB] = f[`FLD_AMBIENT_MSB:`FLD_AMBIENT_LSB]
                                           | AMBIENT_STATUS;
    end
    st_nxt.flags = f;
    // pin follows the flags in the same cycle that they change
    st_nxt.int_n = ~|(f & IRQ_ENABLE);
    // registered read data; unmapped offsets read zero
    if (REG_RD) begin
      if (REG_ADDR == `OFS_PARAMETER_BOX) begin
        st_nxt.rdata = st_r.param;
      end else if (REG_ADDR == `OFS_COMMAND_MAILBOX) begin
        st_nxt.rdata = st_r.command;
      end else if (REG_ADDR == `OFS_RESPONSE_CODE) begin
        st_nxt.rdata = resp;
      end else if (REG_ADDR == `OFS_INTERRUPT_FLAGS) begin
        st_nxt.rdata = {2'h0, st_r.flags};
      end else if (REG_ADDR == `OFS_VISIBLE_LOW) begin
        st_nxt.rdata = st_r.vis[7:0];
      end else if (REG_ADDR == `OFS_VISIBLE_HIGH) begin
        st_nxt.rdata = st_r.vis[15:8];
      end else if (REG_ADDR == `OFS_INFRARED_LOW) begin
        st_nxt.rdata = st_r.ir[7:0];
      end else if (REG_ADDR == `OFS_INFRARED_HIGH) begin
        st_nxt.rdata = st_r.ir[15:8];
      end else begin
        st_nxt.rdata = `RST_BYTE;
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_r.command    <= `RST_BYTE;
      st_r.param      <= `RST_BYTE;
      st_r.flags      <= `RST_FLAGS;
      st_r.vis        <= `RST_WORD;
      st_r.ir         <= `RST_WORD;
      st_r.rdata      <= `RST_BYTE;
      st_r.wake       <= 1'b0;
      st_r.issue      <= 1'b0;
      st_r.issue_code <= `RST_BYTE;
      st_r.int_n      <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign REG_RDATA       = st_r.rdata;
  assign WAKE            = st_r.wake;
  assign CMD_ISSUE       = st_r.issue;
  assign CMD_CODE        = st_r.issue_code;
  assign PARAMETER_VALUE = st_r.param;
  assign RESPONSE_CODE   = resp;
  assign INT_N           = st_r.int_n;

  // ==========================================================
  // checks
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);

  a_wake_on_cmd: assert property (
    cmd_wr |=> WAKE ##1 !WAKE || $past(cmd_wr))
    else $error("command write did not wake");

  a_wake_only_cmd: assert property (
    !cmd_wr |=> !WAKE)
    else $error("wake without command write");

  a_ignore_cmd: assert property (
    cmd_wr && resp[`BIT_ERROR] && !clear_cmd |=> !CMD_ISSUE)
    else $error("command passed while error held");

  a_clear_cmd: assert property (
    cmd_wr && resp[`BIT_ERROR] && clear_cmd && !err_valid && !CMD_DONE
    |=> CMD_ISSUE && resp == 8'h00 && CMD_CODE == $past(REG_WDATA))
    else $error("clearing command did not clear error");

  a_issue_code: assert property (
    cmd_accept |=> CMD_ISSUE && CMD_CODE == $past(REG_WDATA))
    else $error("accepted command not issued");

  a_no_issue_idle: assert property (
    !cmd_accept |=> !CMD_ISSUE)
    else $error("issue without accepted command");

  a_meas_in_error: assert property (
    resp[`BIT_ERROR] && PROX_EVENT[0] |=> flags[2])
    else $error("measurement flag lost during error");

  a_invalid_code: assert property (
    CMD_INVALID && !resp[`BIT_ERROR] && !resp_wr |=> resp == 8'h80)
    else $error("invalid command code wrong");

  a_prox_ovf_code: assert property (
    !CMD_INVALID && OVF_EVENT == 6'h02 && !resp[`BIT_ERROR] && !resp_wr
    |=> resp == 8'h89)
    else $error("proximity overflow code wrong");

  a_aux_ovf_code: assert property (
    !CMD_INVALID && OVF_EVENT == 6'h20 && !resp[`BIT_ERROR] && !resp_wr
    |=> resp == 8'h8E)
    else $error("auxiliary overflow code wrong");

  a_done_flag: assert property (
    CMD_DONE |=> flags[5])
    else $error("command done flag not set");

  a_reserved_zero: assert property (
    REG_RD && REG_ADDR == `OFS_INTERRUPT_FLAGS |=> REG_RDATA[7:6] == 2'h0)
    else $error("reserved flag bits not zero");

  a_rdata_hold: assert property (
    !REG_RD |=> REG_RDATA == $past(REG_RDATA))
    else $error("read data changed without read");

  a_result_hold: assert property (
    !VIS_LOAD && !(REG_WR && (REG_ADDR == `OFS_VISIBLE_LOW || REG_ADDR == `OFS_VISIBLE_HIGH))
    |=> st_r.vis == $past(st_r.vis))
    else $error("visible result changed without load");

  a_int_pin: assert property (
    ##1 INT_N == ~|(flags & $past(IRQ_ENABLE)))
    else $error("interrupt pin mismatch");

  a_flag_w1c: assert property (
    flags_wr && REG_WDATA[5] && !CMD_DONE |=> !flags[5])
    else $error("write one did not clear flag");

  a_flag_sticky: assert property (
    flags[3] && !(flags_wr && REG_WDATA[3]) && !(INT_MODE && AUTO_CLEAR) |=> flags[3])
    else $error("flag dropped without clear");

  a_auto_keep: assert property (
    INT_MODE && AUTO_CLEAR && PROX_ALERT_MODE[1:0] == 2'h3 && flags[2] && !flags_wr
    |=> flags[2])
    else $error("sticky proximity flag auto cleared");

  a_auto_clear: assert property (
    INT_MODE && AUTO_CLEAR && !CMD_DONE && !AMBIENT_EVENT
    |=> !flags[5] && flags[1:0] == 2'h0)
    else $error("auto clear left flags set");

  a_vis_load: assert property (
    VIS_LOAD |=> REG_RD && REG_ADDR == 8'h23 && !VIS_LOAD
    |=> REG_RDATA == $past(VIS_RESULT[15:8], 2))
    else $error("visible high byte wrong");

  a_ir_load: assert property (
    IR_LOAD |=> REG_RD && REG_ADDR == 8'h25 && !IR_LOAD
    |=> REG_RDATA == $past(IR_RESULT[15:8], 2))
    else $error("infrared high byte wrong");

  a_param_box: assert property (
    REG_WR && REG_ADDR == 8'h17 |=> PARAMETER_VALUE == $past(REG_WDATA))
    else $error("parameter mailbox not written");

endmodule

//--- verif/host_bus_model.sv
// host-side model driving the byte register port of the block
`timescale 1ns/1ps

module host_bus_model (
  input  wire logic       CLK,
  output logic      [7:0] REG_ADDR,
  output logic            REG_WR,
  output logic      [7:0] REG_WDATA,
  output logic            REG_RD,
  input  wire logic [7:0] REG_RDATA,
  input  wire logic       INT_N
);
  // ==========================================================
  // idle levels
  initial begin
    REG_ADDR  = 8'hFF;
    REG_WR    = 1'b0;
    REG_WDATA = 8'hFF;
    REG_RD    = 1'b0;
  end

  // ==========================================================
  // byte accesses
  // released lines show the inverse so a stale value can never pass for a match
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge CLK);
    #1;
    REG_ADDR  = addr;
    REG_WDATA = data;
    REG_WR    = 1'b1;
    @(posedge CLK);
    #1;
    REG_WR    = 1'b0;
    REG_ADDR  = ~addr;
    REG_WDATA = ~data;
  endtask

  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge CLK);
    #1;
    REG_ADDR = addr;
    REG_RD   = 1'b1;
    @(posedge CLK);
    #1;
    REG_RD   = 1'b0;
    REG_ADDR = ~addr;
    data     = REG_RDATA;
  endtask

  // completion is seen as a counter change, never as a fixed wait
  task automatic poll(input logic [7:0] old, output logic [7:0] now);
    now = old;
    for (int k = 0; k < 64 && now === old; k++) begin
      rd(8'h20, now);
    end
  endtask
endmodule

//--- verif/sensor_command_core_tb.sv
// self-checking bench of the command, response and status block
`timescale 1ns/1ps

module sensor_command_core_tb;
  logic        CLK;
  logic        NRST;
  logic [7:0]  REG_ADDR;
  logic        REG_WR;
  logic [7:0]  REG_WDATA;
  logic        REG_RD;
  logic [7:0]  REG_RDATA;
  logic        WAKE;
  logic        CMD_ISSUE;
  logic [7:0]  CMD_CODE;
  logic [7:0]  PARAMETER_VALUE;
  logic        CMD_DONE;
  logic        CMD_INVALID;
  logic [5:0]  OVF_EVENT;
  logic [2:0]  PROX_EVENT;
  logic        AMBIENT_EVENT;
  logic [1:0]  AMBIENT_STATUS;
  logic        AUTO_CLEAR;
  logic        INT_MODE;
  logic [5:0]  IRQ_ENABLE;
  logic [5:0]  PROX_ALERT_MODE;
  logic        VIS_LOAD;
  logic [15:0] VIS_RESULT;
  logic        IR_LOAD;
  logic [15:0] IR_RESULT;
  logic [7:0]  RESPONSE_CODE;
  logic        INT_N;
  int          err_count;
  int          samples_checked;
  int          cycles;
  logic [3:0]  cnt;
  logic [7:0]  rv;

  sensor_command_core sensor_command_core_inst (
    .CLK(CLK), .NRST(NRST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .WAKE(WAKE), .CMD_ISSUE(CMD_ISSUE),
    .CMD_CODE(CMD_CODE), .PARAMETER_VALUE(PARAMETER_VALUE), .CMD_DONE(CMD_DONE),
    .CMD_INVALID(CMD_INVALID), .OVF_EVENT(OVF_EVENT), .PROX_EVENT(PROX_EVENT),
    .AMBIENT_EVENT(AMBIENT_EVENT), .AMBIENT_STATUS(AMBIENT_STATUS), .AUTO_CLEAR(AUTO_CLEAR),
    .INT_MODE(INT_MODE), .IRQ_ENABLE(IRQ_ENABLE), .PROX_ALERT_MODE(PROX_ALERT_MODE),
    .VIS_LOAD(VIS_LOAD), .VIS_RESULT(VIS_RESULT), .IR_LOAD(IR_LOAD), .IR_RESULT(IR_RESULT),
    .RESPONSE_CODE(RESPONSE_CODE), .INT_N(INT_N));

  host_bus_model host_bus_model_inst (
    .CLK(CLK), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .INT_N(INT_N));

  // ==========================================================
  // clock and watchdog
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  // ==========================================================
  // helpers
  task automatic print_verdict();
    if (err_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step();
    @(posedge CLK);
    #1;
  endtask

  // one-cycle sequencer event pulses, entered just after an edge
  task automatic ev(input logic d, input logic inv, input logic [5:0] ovf,
                    input logic [2:0] prox, input logic amb, input logic clr);
    step();
    CMD_DONE      = d;
    CMD_INVALID   = inv;
    OVF_EVENT     = ovf;
    PROX_EVENT    = prox;
    AMBIENT_EVENT = amb;
    AUTO_CLEAR    = clr;
    step();
    CMD_DONE      = 1'b0;
    CMD_INVALID   = 1'b0;
    OVF_EVENT     = 6'h00;
    PROX_EVENT    = 3'h0;
    AMBIENT_EVENT = 1'b0;
    AUTO_CLEAR    = 1'b0;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [7:0] offs [9] = '{8'h17, 8'h18, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h30};
    chk("int_n after reset", 8'h01, {7'h0, INT_N});
    foreach (offs[k]) begin
      host_bus_model_inst.rd(offs[k], rv);
      chk("reset read", 8'h00, rv);
    end
  endtask

  task automatic t_command();
    host_bus_model_inst.wr(8'h17, 8'h5A);
    chk("parameter value", 8'h5A, PARAMETER_VALUE);
    chk("no wake on parameter", 8'h00, {7'h0, WAKE});
    host_bus_model_inst.wr(8'h18, 8'h05);
    chk("wake", 8'h01, {7'h0, WAKE});
    chk("issue", 8'h01, {7'h0, CMD_ISSUE});
    chk("command code", 8'h05, CMD_CODE);
    step();
    chk("wake pulse", 8'h00, {7'h0, WAKE});
    fork
      begin
        repeat (7) step();
        ev(1'b1, 1'b0, 6'h00, 3'h0, 1'b0, 1'b0);
      end
      host_bus_model_inst.poll(8'h00, rv);
    join
    chk("counter", 8'h01, rv);
    host_bus_model_inst.rd(8'h21, rv);
    chk("done flag", 8'h20, rv & 8'h20);
  endtask

  task automatic t_wrap();
    cnt = 4'h1;
    repeat (16) begin
      ev(1'b1, 1'b0, 6'h00, 3'h0, 1'b0, 1'b0);
      cnt = cnt + 4'h1;
      chk("rolling counter", {4'h0, cnt}, RESPONSE_CODE);
    end
  endtask

  task automatic t_errors();
    logic [7:0] codes [7] = '{8'h80, 8'h88, 8'h89, 8'h8A, 8'h8C, 8'h8D, 8'h8E};
    for (int k = 0; k < 7; k++) begin
      ev(1'b0, k == 0, (k == 0) ? 6'h00 : 6'h01 << (k - 1), 3'h0, 1'b0, 1'b0);
      chk("error code", codes[k], RESPONSE_CODE);
      // later completions and errors must not disturb the held code
      ev(1'b1, 1'b0, 6'h3F, 3'h0, 1'b0, 1'b0);
      chk("held code", codes[k], RESPONSE_CODE);
      host_bus_model_inst.wr(8'h18, 8'h05);
      chk("ignored issue", 8'h00, {7'h0, CMD_ISSUE});
      chk("wake while held", 8'h01, {7'h0, WAKE});
      ev(1'b0, 1'b0, 6'h00, 3'h1, 1'b0, 1'b0);
      host_bus_model_inst.rd(8'h21, rv);
      chk("measuring goes on", 8'h04, rv & 8'h04);
      host_bus_model_inst.wr(8'h18, (k % 2 == 1) ? 8'h01 : 8'h00);
      chk("clearing issue", 8'h01, {7'h0, CMD_ISSUE});
      chk("cleared code", 8'h00, RESPONSE_CODE);
    end
  endtask

  task automatic t_flags();
    IRQ_ENABLE = 6'h3F;
    host_bus_model_inst.wr(8'h21, 8'hFF);
    step();
    chk("int idle", 8'h01, {7'h0, INT_N});
    for (int k = 0; k < 3; k++) begin
      ev(1'b0, 1'b0, 6'h00, 3'h1 << k, 1'b0, 1'b0);
      chk("int set", 8'h00, {7'h0, INT_N});
      host_bus_model_inst.rd(8'h21, rv);
      chk("proximity flag", 8'h04 << k, rv);
      host_bus_model_inst.wr(8'h21, 8'h04 << k);
      step();
      chk("int released", 8'h01, {7'h0, INT_N});
    end
    IRQ_ENABLE     = 6'h00;
    AMBIENT_STATUS = 2'b10;
    ev(1'b0, 1'b0, 6'h00, 3'h0, 1'b1, 1'b0);
    step();
    chk("masked flag", 8'h01, {7'h0, INT_N});
    host_bus_model_inst.rd(8'h21, rv);
    chk("ambient field", 8'h02, rv);
    IRQ_ENABLE = 6'h02;
    step();
    step();
    chk("enabled flag", 8'h00, {7'h0, INT_N});
    host_bus_model_inst.wr(8'h21, 8'h01);
    step();
    chk("other bit kept", 8'h00, {7'h0, INT_N});
    host_bus_model_inst.wr(8'h21, 8'h02);
    step();
    chk("ambient cleared", 8'h01, {7'h0, INT_N});
  endtask

  task automatic t_auto();
    IRQ_ENABLE      = 6'h3F;
    PROX_ALERT_MODE = 6'h03;
    ev(1'b0, 1'b0, 6'h00, 3'h7, 1'b0, 1'b0);
    ev(1'b0, 1'b0, 6'h00, 3'h0, 1'b0, 1'b1);
    host_bus_model_inst.rd(8'h21, rv);
    chk("no auto clear at policy 0", 8'h1C, rv);
    INT_MODE = 1'b1;
    ev(1'b0, 1'b0, 6'h00, 3'h0, 1'b0, 1'b1);
    host_bus_model_inst.rd(8'h21, rv);
    chk("sticky flag kept", 8'h04, rv);
    chk("int kept", 8'h00, {7'h0, INT_N});
    INT_MODE        = 1'b0;
    PROX_ALERT_MODE = 6'h00;
    host_bus_model_inst.wr(8'h21, 8'h3F);
  endtask

  task automatic t_results();
    logic [7:0] exp [4] = '{8'h34, 8'h12, 8'hCD, 8'hAB};
    host_bus_model_inst.wr(8'h20, 8'h07);
    chk("response write", 8'h07, RESPONSE_CODE);
    VIS_RESULT     = 16'h1234;
    IR_RESULT      = 16'hABCD;
    VIS_LOAD       = 1'b1;
    IR_LOAD        = 1'b1;
    AMBIENT_STATUS = 2'b01;
    AMBIENT_EVENT  = 1'b1;
    // read the high byte in the cycle right after the load
    fork
      begin
        step();
        VIS_LOAD       = 1'b0;
        IR_LOAD        = 1'b0;
        AMBIENT_EVENT  = 1'b0;
        VIS_RESULT     = 16'h0F0F;
        IR_RESULT      = 16'hF0F0;
      end
      host_bus_model_inst.rd(8'h23, rv);
    join
    chk("fresh high byte", 8'h12, rv);
    for (int k = 0; k < 20 && INT_N !== 1'b0; k++) begin
      step();
    end
    for (int k = 0; k < 4; k++) begin
      host_bus_model_inst.rd(8'h22 + 8'(k), rv);
      chk("result byte", exp[k], rv);
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    err_count       = 0;
    samples_checked = 0;
    cycles          = 0;
    NRST            = 1'b0;
    {CMD_DONE, CMD_INVALID, AMBIENT_EVENT, AUTO_CLEAR, INT_MODE} = 5'h00;
    OVF_EVENT       = 6'h00;
    PROX_EVENT      = 3'h0;
    AMBIENT_STATUS  = 2'b00;
    IRQ_ENABLE      = 6'h00;
    PROX_ALERT_MODE = 6'h00;
    {VIS_LOAD, IR_LOAD} = 2'b00;
    VIS_RESULT      = 16'h0000;
    IR_RESULT       = 16'h0000;
    repeat (20) @(posedge CLK);
    #1;
    NRST = 1'b1;
    t_reset();
    t_command();
    t_wrap();
    t_errors();
    t_flags();
    t_auto();
    t_results();
    print_verdict();
  end
endmodule
